// ---- flash_cfg.svh ----
// Numeric constants of the wide fast-read link and the controller registers.
// Included by the host and device design files and the testbench; holds definitions only.
`ifndef FLASH_LINK_CFG_SVH
`define FLASH_LINK_CFG_SVH
// Opcodes
`define OP_DUAL_OUT   8'h3B
`define OP_QUAD_OUT   8'h6B
`define OP_QUAD_IO    8'hEB
// Phase lengths in link clock cycles
`define CYC_CMD_SPI   8'h08
`define CYC_CMD_QPI   8'h02
`define CYC_ADR_SPI   8'h18
`define CYC_ADR_QUAD  8'h06
`define CYC_DMY_OUT   8'h08
`define CYC_MODE      8'h02
`define DUMMY_DEFAULT 4'h6
// Mode byte
`define MODE_CONT     4'hA
`define MODE_ON       8'hA0
`define MODE_OFF      8'h00
// Lanes per cycle
`define W_ONE         3'h1
`define W_QUAD        3'h4
// Controller register offsets
`define REG_CTRL      3'h0
`define REG_ADDR      3'h1
`define REG_LEN       3'h2
`define REG_STAT      3'h3
`define REG_DATA      3'h4
// Control fields
`define CTRL_KIND     1:0
`define CTRL_CONT     2
`define CTRL_SKIP     3
`define CTRL_QPI      4
`define CTRL_DUMMY    11:8
`endif

// ---- flash_link_if.sv ----
// Serial link between the flash host controller and the flash device.
// Resolves the four shared IO lines from both enables; an undriven line
// reads high as with a pull-up.
interface flash_link_if;
  logic       sck;
  logic       cs_n;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  for (genvar i = 0; i < 4; i++) begin : g_io
    assign io[i] = d_io_oe[i] ? d_io_o[i] : (h_io_oe[i] ? h_io_o[i] : 1'b1);
  end

  modport host (output sck, cs_n, h_io_o, h_io_oe, input io);
  modport dev  (input sck, cs_n, io, output d_io_o, d_io_oe);
endinterface : flash_link_if

// ---- flash_link_sva.sv ----
// Checker for the wide fast-read link between the host and device ends.
// Takes the interface lines as plain inputs; the bench instantiates it.
module flash_link_sva (
  // Link clock and reset
  input wire logic       sck,
  input wire logic       RESET_N,
  // Link lines
  input wire logic       cs_n,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge sck);
  endclocking
  default disable iff (!RESET_N);

  sequence frame_start;
    $fell(cs_n);
  endsequence
  sequence header_quiet;
    (d_io_oe == 4'h0) [*8];
  endsequence
  sequence host_hands_over;
    $fell(h_io_oe[3]) && !cs_n;
  endsequence

  a_release_on_deselect: assert property (cs_n |-> d_io_oe == 4'h0)
    else $error("device drives a lane while deselected");
  a_host_idle_release: assert property (cs_n |-> h_io_oe == 4'h0)
    else $error("host drives a lane outside a frame");
  a_no_lane_contention: assert property ((d_io_oe & h_io_oe) == 4'h0)
    else $error("host and device drive one lane together");
  a_lane_groups_legal: assert property (d_io_oe inside {4'h0, 4'h3, 4'hF})
    else $error("device drives an illegal lane group");
  a_header_quiet: assert property (frame_start |-> header_quiet)
    else $error("device drives during the frame header");
  a_host_leads_frame: assert property (frame_start |-> h_io_oe inside {4'h1, 4'hF})
    else $error("host header lanes wrong at frame start");
  a_drive_held_steady: assert property ((d_io_oe != 4'h0) && !cs_n |=> cs_n || $stable(d_io_oe))
    else $error("device lane group changed inside a frame");
  a_data_after_mode: assert property (host_hands_over |-> ##[1:16] (d_io_oe == 4'hF || cs_n))
    else $error("no quad data after the dummy period");
endmodule : flash_link_sva

// ---- flash_pkg.sv ----
// Types shared by both ends of the wide fast-read link.
// Assumes flash_cfg.svh supplies the numeric constants.
package flash_pkg;
  typedef enum logic [1:0] {RK_DUAL, RK_QUAD_OUT, RK_QUAD_IO} read_kind_t;
  typedef enum {S_CMD, S_ADR, S_DMY, S_DAT, S_IGN} dev_state_t;
  typedef enum {H_IDLE, H_RUN} host_state_t;
endpackage : flash_pkg

// ---- flash_read_device.sv ----
// Device end of the wide fast-read link: opcode, address, mode, dummy and
// data phases, clocked by the link clock from the host.
// Assumes a combinational array behind MEM_ADDR/MEM_DATA and a link clock
// that keeps running while select is high, so reset can reach this logic.
// Contract
// - Dual-output read: opcode, address, 8 dummies on IO0
// - Dual data: MSB on IO1, next on IO0
// - Address increments per byte, wraps to zero
// - Read runs until select rises, then release
// - Reads ignored while write in progress
// - Host sets quad enable before quad-output
// - Quad-output: serial header, data MSB on IO3
// - Host sets quad enable before quad-IO read
// - Quad-IO address four bits per cycle
// - Quad-IO dummies configurable, default six
// - First two dummies carry the mode byte
// - Mode nibble A enters continuous read
// - Other nibble leaves continuous read
// - Continuous read keeps command line mode
// - Six dummies: mode plus four more
// - Four-line mode needs no quad enable
// - Four-line opcode takes two cycles
// - Busy flag high while program or erase
`include "flash_cfg.svh"
module flash_read_device
  import flash_pkg::*;
(
  // Link
  flash_link_if.dev        LINK,
  // Reset, synchronised to the link clock
  input  wire logic        RESET_N,
  // Status and configuration from the array controller
  input  wire logic        WRITE_IN_PROGRESS_FLAG,
  input  wire logic        QUAD_ENABLE,
  input  wire logic        QPI_MODE,
  input  wire logic [3:0]  DUMMY_CYCLES,
  // Array read port
  output logic      [23:0] MEM_ADDR,
  input  wire logic [7:0]  MEM_DATA,
  // Continuous read state
  output logic             CONT_MODE
);

  logic [7:0]  cfg_s;
  logic        rst_n_s;
  logic        wip_s;
  logic        qe_s;
  logic        qpi_s;
  logic [7:0]  dummy_s;

  dev_state_t  st_ff;
  dev_state_t  nxt_st;
  logic [7:0]  cnt_ff;
  logic [7:0]  nxt_cnt;
  logic [23:0] sh_ff;
  logic [23:0] nxt_sh;
  read_kind_t  kind_ff;
  read_kind_t  nxt_kind;
  logic [23:0] addr_ff;
  logic [23:0] nxt_addr;
  logic [7:0]  mode_ff;
  logic [7:0]  nxt_mode;
  logic        cont_ff;
  logic        nxt_cont;
  logic [1:0]  beat_ff;
  logic [1:0]  nxt_beat;
  logic [3:0]  out_ff;
  logic [3:0]  nxt_out;
  logic [3:0]  oe_ff;
  logic [3:0]  nxt_oe;

  // Shift one (IO0) or four (IO3 first) bits into the header register
  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io,
                                           input logic wide);
    shift_in = wide ? {sh[19:0], io} : {sh[22:0], io[0]};
  endfunction : shift_in

  // Lane group of a data byte for one output cycle
  function automatic logic [3:0] data_group(input logic [7:0] b, input logic [1:0] beat,
                                            input read_kind_t kind);
    logic [7:0] s;
    s = 8'h00;
    if (kind == RK_DUAL) begin
      s = b << {beat, 1'b0};
      data_group = {2'h0, s[7:6]};
    end else begin
      s = b << {beat[0], 2'h0};
      data_group = s[7:4];
    end
  endfunction : data_group

  sync2 #(
    .W (8)
  ) u_sync (
    .clk (LINK.sck),
    .d   ({RESET_N, WRITE_IN_PROGRESS_FLAG, QUAD_ENABLE, QPI_MODE, DUMMY_CYCLES}),
    .q   (cfg_s)
  );

  assign rst_n_s = cfg_s[7];
  assign wip_s   = cfg_s[6];
  assign qe_s    = cfg_s[5];
  assign qpi_s   = cfg_s[4];
  assign dummy_s = {4'h0, cfg_s[3:0] == 4'h0 ? `DUMMY_DEFAULT : cfg_s[3:0]};

  // Header and sequencing, sampled on rising link clock edges
  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff + 8'h01;
    nxt_sh   = sh_ff;
    nxt_kind = kind_ff;
    nxt_addr = addr_ff;
    nxt_mode = mode_ff;
    nxt_cont = cont_ff;
    nxt_beat = beat_ff;
    case (st_ff)
      S_CMD: begin
        nxt_sh = shift_in(sh_ff, LINK.io, qpi_s);
        if (cnt_ff == (qpi_s ? `CYC_CMD_QPI : `CYC_CMD_SPI) - 8'h01) begin
          nxt_cnt = 8'h00;
          nxt_st  = S_ADR;
          if (wip_s) begin
            nxt_st = S_IGN;
          end else if (nxt_sh[7:0] == `OP_DUAL_OUT && !qpi_s) begin
            nxt_kind = RK_DUAL;
          end else if (nxt_sh[7:0] == `OP_QUAD_OUT && !qpi_s && qe_s) begin
            nxt_kind = RK_QUAD_OUT;
          end else if (nxt_sh[7:0] == `OP_QUAD_IO && (qpi_s || qe_s)) begin
            nxt_kind = RK_QUAD_IO;
          end else begin
            nxt_st = S_IGN;
          end
        end
      end
      S_ADR: begin
        nxt_sh = shift_in(sh_ff, LINK.io, kind_ff == RK_QUAD_IO);
        if (cnt_ff == (kind_ff == RK_QUAD_IO ? `CYC_ADR_QUAD : `CYC_ADR_SPI) - 8'h01) begin
          nxt_cnt  = 8'h00;
          nxt_addr = nxt_sh;
          nxt_st   = S_DMY;
        end
      end
      S_DMY: begin
        if (kind_ff == RK_QUAD_IO && cnt_ff < `CYC_MODE) begin
          nxt_mode = {mode_ff[3:0], LINK.io};
          if (cnt_ff == `CYC_MODE - 8'h01) begin
            // Only the next frame's start and the CONT_MODE output look at this flag
            nxt_cont = (nxt_mode[7:4] == `MODE_CONT);
          end
        end
        if (cnt_ff == (kind_ff == RK_QUAD_IO ? dummy_s : `CYC_DMY_OUT) - 8'h01) begin
          nxt_st   = S_DAT;
          nxt_beat = 2'h0;
        end
      end
      S_DAT: begin
        nxt_beat = beat_ff + 2'h1;
        if (beat_ff == (kind_ff == RK_DUAL ? 2'h3 : 2'h1)) begin
          nxt_beat = 2'h0;
          nxt_addr = addr_ff + 24'h000001;
        end
      end
      S_IGN: begin
        nxt_cnt = cnt_ff;
      end
      default: begin
        nxt_st = S_IGN;
      end
    endcase
    if (LINK.cs_n) begin
      // Continuous read skips the opcode; command line mode untouched
      nxt_cnt  = 8'h00;
      nxt_beat = 2'h0;
      nxt_st   = cont_ff ? (wip_s ? S_IGN : S_ADR) : S_CMD;
      nxt_kind = cont_ff ? RK_QUAD_IO : kind_ff;
    end
    if (!rst_n_s) begin
      nxt_st   = S_CMD;
      nxt_cnt  = 8'h00;
      nxt_cont = 1'b0;
      nxt_kind = RK_DUAL;
    end
  end

  always_ff @(posedge LINK.sck) begin
    st_ff   <= nxt_st;
    cnt_ff  <= nxt_cnt;
    sh_ff   <= nxt_sh;
    kind_ff <= nxt_kind;
    addr_ff <= nxt_addr;
    mode_ff <= nxt_mode;
    cont_ff <= nxt_cont;
    beat_ff <= nxt_beat;
  end

  // Data lanes, driven on falling link clock edges
  always_comb begin
    nxt_out = 4'h0;
    nxt_oe  = 4'h0;
    if (st_ff == S_DAT) begin
      nxt_out = data_group(MEM_DATA, beat_ff, kind_ff);
      nxt_oe  = (kind_ff == RK_DUAL) ? 4'h3 : 4'hF;
    end
  end

  // Select high releases the lanes at once, not at the next fall
  always_ff @(negedge LINK.sck or posedge LINK.cs_n) begin
    if (LINK.cs_n) begin
      out_ff <= 4'h0;
      oe_ff  <= 4'h0;
    end else begin
      out_ff <= nxt_out;
      oe_ff  <= nxt_oe;
    end
  end

  assign LINK.d_io_o  = out_ff;
  assign LINK.d_io_oe = oe_ff;
  assign MEM_ADDR     = addr_ff;
  assign CONT_MODE    = cont_ff;
endmodule : flash_read_device

// ---- flash_read_host.sv ----
// Host end of the wide fast-read link: makes the link clock by dividing
// CLK, sends the header and collects data bytes into registers.
// Assumes software polls the status register fast enough for each byte.
`include "flash_cfg.svh"
module flash_read_host
  import flash_pkg::*;
#(
  parameter int HALF = 2
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // Register port
  input  wire logic [2:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // Link
  flash_link_if.host       LINK
);

  logic [3:0]  io_s;
  host_state_t st_ff, nxt_st;
  logic [7:0]  div_ff, nxt_div;
  logic        sck_ff, nxt_sck;
  logic        cs_n_ff, nxt_cs_n;
  logic [7:0]  k_ff, nxt_k;
  logic [39:0] sh_ff, nxt_sh;
  logic [7:0]  drv_ff, nxt_drv;
  logic [7:0]  rx_ff, nxt_rx;
  logic [1:0]  beat_ff, nxt_beat;
  logic [15:0] left_ff, nxt_left;
  logic [7:0]  data_ff, nxt_data;
  logic        valid_ff, nxt_valid;
  logic        go_ff, nxt_go;
  logic [11:0] ctrl_ff, nxt_ctrl;
  logic [23:0] addr_ff, nxt_addr;
  logic [15:0] len_ff, nxt_len;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        quadio, four_line_command_mode, fall, busy;
  logic [7:0]  t_cmd, t_adr, t_out, t_dum, opcode;

  function automatic logic [2:0] lane_w(input logic [7:0] c, input logic [7:0] tc,
                                        input logic q4, input logic qio);
    lane_w = ((c < tc) ? q4 : qio) ? `W_QUAD : `W_ONE;
  endfunction : lane_w

  function automatic logic [7:0] drive(input logic [39:0] sh, input logic [2:0] w,
                                       input logic en);
    drive = 8'h00;
    if (en) begin
      drive = (w == `W_QUAD) ? {4'hF, sh[39:36]} : {4'h1, 3'h0, sh[39]};
    end
  endfunction : drive

  sync2 #(
    .W (4)
  ) u_sync (
    .clk (CLK),
    .d   (LINK.io),
    .q   (io_s)
  );

  assign quadio = (ctrl_ff[`CTRL_KIND] == RK_QUAD_IO);
  assign four_line_command_mode    = ctrl_ff[`CTRL_QPI];
  assign t_cmd  = ctrl_ff[`CTRL_SKIP] ? 8'h00 : (four_line_command_mode ? `CYC_CMD_QPI : `CYC_CMD_SPI);
  assign t_adr  = t_cmd + (quadio ? `CYC_ADR_QUAD : `CYC_ADR_SPI);
  // Lines released after the mode cycles in quad-IO, after the address otherwise
  assign t_out  = t_adr + (quadio ? `CYC_MODE : 8'h00);
  assign t_dum  = t_adr + (quadio ? {4'h0, ctrl_ff[`CTRL_DUMMY]} : `CYC_DMY_OUT);
  assign opcode = (ctrl_ff[`CTRL_KIND] == RK_DUAL) ? `OP_DUAL_OUT :
                  (ctrl_ff[`CTRL_KIND] == RK_QUAD_OUT) ? `OP_QUAD_OUT : `OP_QUAD_IO;
  assign fall   = (div_ff == 8'(HALF - 1)) && sck_ff;
  assign busy   = go_ff || (st_ff == H_RUN);

  always_comb begin
    nxt_st    = st_ff;
    nxt_div   = (div_ff == 8'(HALF - 1)) ? 8'h00 : div_ff + 8'h01;
    nxt_sck   = (div_ff == 8'(HALF - 1)) ? !sck_ff : sck_ff;
    nxt_cs_n  = cs_n_ff;
    nxt_k     = k_ff;
    nxt_sh    = sh_ff;
    nxt_drv   = drv_ff;
    nxt_rx    = rx_ff;
    nxt_beat  = beat_ff;
    nxt_left  = left_ff;
    nxt_data  = data_ff;
    nxt_valid = valid_ff;
    nxt_go    = go_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_addr  = addr_ff;
    nxt_len   = len_ff;
    nxt_rdata = 32'h0000_0000;
    if (RD) begin
      case (ADDR)
        `REG_CTRL: nxt_rdata = {20'h00000, ctrl_ff};
        `REG_ADDR: nxt_rdata = {8'h00, addr_ff};
        `REG_LEN:  nxt_rdata = {16'h0000, len_ff};
        `REG_STAT: nxt_rdata = {30'h0000_0000, valid_ff, busy};
        `REG_DATA: nxt_rdata = {24'h000000, data_ff};
        default:   nxt_rdata = 32'h0000_0000;
      endcase
      if (ADDR == `REG_DATA) begin
        nxt_valid = 1'b0;
      end
    end
    // Setup writes are refused while a frame is pending or running
    if (WR && !busy) begin
      case (ADDR)
        `REG_CTRL: begin
          nxt_ctrl = WDATA[11:0];
          nxt_go   = (len_ff != 16'h0000);
        end
        `REG_ADDR: nxt_addr = WDATA[23:0];
        `REG_LEN:  nxt_len  = WDATA[15:0];
        default:   nxt_len  = len_ff;
      endcase
    end
    case (st_ff)
      H_IDLE: begin
        if (go_ff && fall) begin
          nxt_go   = 1'b0;
          nxt_st   = H_RUN;
          nxt_cs_n = 1'b0;
          nxt_k    = 8'h00;
          nxt_beat = 2'h0;
          nxt_left = len_ff;
          nxt_sh   = ctrl_ff[`CTRL_SKIP] ?
                     {addr_ff, ctrl_ff[`CTRL_CONT] ? `MODE_ON : `MODE_OFF, 8'h00} :
                     {opcode, addr_ff, ctrl_ff[`CTRL_CONT] ? `MODE_ON : `MODE_OFF};
          nxt_drv  = drive(nxt_sh, lane_w(8'h00, t_cmd, four_line_command_mode, quadio), t_out != 8'h00);
        end
      end
      H_RUN: begin
        if (fall) begin
          nxt_sh  = (lane_w(k_ff, t_cmd, four_line_command_mode, quadio) == `W_QUAD) ?
                    {sh_ff[35:0], 4'h0} : {sh_ff[38:0], 1'b0};
          nxt_k   = (k_ff < t_dum) ? k_ff + 8'h01 : k_ff;
          nxt_drv = drive(nxt_sh, lane_w(nxt_k, t_cmd, four_line_command_mode, quadio), nxt_k < t_out);
          if (k_ff >= t_dum) begin
            nxt_rx   = (ctrl_ff[`CTRL_KIND] == RK_DUAL) ?
                       {rx_ff[5:0], io_s[1:0]} : {rx_ff[3:0], io_s};
            nxt_beat = beat_ff + 2'h1;
            if (beat_ff == ((ctrl_ff[`CTRL_KIND] == RK_DUAL) ? 2'h3 : 2'h1)) begin
              nxt_beat  = 2'h0;
              nxt_data  = nxt_rx;
              nxt_valid = 1'b1;
              nxt_left  = left_ff - 16'h0001;
              if (left_ff == 16'h0001) begin
                nxt_st   = H_IDLE;
                nxt_cs_n = 1'b1;
                nxt_drv  = 8'h00;
              end
            end
          end
        end
      end
      default: nxt_st = H_IDLE;
    endcase
    if (!RESET_N) begin
      nxt_st    = H_IDLE;
      nxt_div   = 8'h00;
      // Link clock keeps toggling so the device's synchronised reset sees edges
      if (sck_ff) begin
        nxt_sck = 1'b0;
      end else begin
        nxt_sck = 1'b1;
      end
      nxt_cs_n  = 1'b1;
      nxt_drv   = 8'h00;
      nxt_valid = 1'b0;
      nxt_go    = 1'b0;
      nxt_ctrl  = {`DUMMY_DEFAULT, 8'h00};
      nxt_addr  = 24'h000000;
      nxt_len   = 16'h0000;
      nxt_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK) begin
    st_ff    <= nxt_st;
    div_ff   <= nxt_div;
    sck_ff   <= nxt_sck;
    cs_n_ff  <= nxt_cs_n;
    k_ff     <= nxt_k;
    sh_ff    <= nxt_sh;
    drv_ff   <= nxt_drv;
    rx_ff    <= nxt_rx;
    beat_ff  <= nxt_beat;
    left_ff  <= nxt_left;
    data_ff  <= nxt_data;
    valid_ff <= nxt_valid;
    go_ff    <= nxt_go;
    ctrl_ff  <= nxt_ctrl;
    addr_ff  <= nxt_addr;
    len_ff   <= nxt_len;
    rdata_ff <= nxt_rdata;
  end

  assign LINK.sck     = sck_ff;
  assign LINK.cs_n    = cs_n_ff;
  assign LINK.h_io_o  = drv_ff[3:0];
  assign LINK.h_io_oe = drv_ff[7:4];
  assign RDATA        = rdata_ff;
endmodule : flash_read_host

// ---- sync2.sv ----
// Two-stage synchroniser for levels entering a clock domain.
// The first stage feeds only the second.
module sync2 #(
  parameter int W = 1
) (
  // Clock
  input  wire logic         clk,
  // Level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk) begin
    meta_ff <= d;
    q_ff    <= meta_ff;
  end

  assign q = q_ff;
endmodule : sync2

// ---- tb_multi_io_fast_read_engine.sv ----
// Testbench: host and device ends joined by the link interface, checker beside it.
// Assumes the design files and flash_cfg.svh are compiled before this file.
`include "flash_cfg.svh"
module tb_multi_io_fast_read_engine
  import flash_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 4;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        write_in_progress_flag = 1'b0;
  logic        qe = 1'b1;
  logic        four_line_command_mode = 1'b0;
  logic [3:0]  dummy = 4'h6;
  logic [23:0] mem_addr;
  logic [7:0]  mem_data;
  logic        cont_mode;
  logic        data_due = 1'b0;
  logic [31:0] seed = 32'h0000002F;
  logic [7:0]  expq[$];
  int          failures = 0;
  int          compares = 0;

  always #50 clk = ~clk;

  flash_link_if i_flash_link_if ();
  flash_read_host #(.HALF(HALF)) i_flash_read_host (
    .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .LINK(i_flash_link_if));
  flash_read_device i_flash_read_device (
    .LINK(i_flash_link_if), .RESET_N(reset_n), .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag), .QUAD_ENABLE(qe),
    .QPI_MODE(four_line_command_mode), .DUMMY_CYCLES(dummy), .MEM_ADDR(mem_addr), .MEM_DATA(mem_data),
    .CONT_MODE(cont_mode));
  flash_link_sva i_flash_link_sva (
    .sck(i_flash_link_if.sck), .RESET_N(reset_n), .cs_n(i_flash_link_if.cs_n),
    .h_io_oe(i_flash_link_if.h_io_oe), .d_io_oe(i_flash_link_if.d_io_oe));

  function automatic logic [7:0] mem_f(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
  endfunction : mem_f

  assign mem_data = mem_f(mem_addr);

  function automatic logic [23:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[23:0];
  endfunction : rnd

  function automatic logic [11:0] ctl(input read_kind_t k, input logic m, input logic s,
                                      input logic q, input logic [3:0] dm);
    return {dm, 3'h0, q, s, m, k};
  endfunction : ctl

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic bus_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  // Device inputs pass two link flops, so let them settle before a frame
  task automatic cfg(input logic w, input logic q, input logic p, input logic [3:0] dm);
    @(posedge clk);
    write_in_progress_flag <= w;
    qe <= q;
    four_line_command_mode <= p;
    dummy <= dm;
    repeat (8 * HALF) @(posedge clk);
  endtask : cfg

  task automatic rd_frame(input logic [11:0] c, input logic [23:0] a, input int n,
                          input logic rej);
    logic [31:0] d;
    logic [23:0] p;
    p = a;
    bus_wr(`REG_ADDR, {8'h00, a});
    bus_wr(`REG_LEN, 32'(n));
    bus_wr(`REG_CTRL, {20'h0, c});
    for (int i = 0; i < n; i++) begin
      d = 32'h0;
      while (d[1] !== 1'b1) bus_rd(`REG_STAT, d);
      // Refused frames leave the lines pulled up
      expq.push_back(rej ? 8'hFF : mem_f(p));
      p = p + 24'h1;
      bus_rd(`REG_DATA, d);
    end
    d = 32'h1;
    while (d[0] !== 1'b0) bus_rd(`REG_STAT, d);
  endtask : rd_frame

  always @(posedge clk) data_due <= rd && (addr == `REG_DATA);

  always @(negedge clk) begin
    if (data_due === 1'b1) check("read_byte", rdata[7:0], expq.pop_front());
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    end_sim();
  end

  initial begin
    // Host toggles the link clock in reset, so two link clock cycles reach the device
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8 * HALF) @(posedge clk);
    rd_frame(ctl(RK_DUAL, 0, 0, 0, 6), 24'hFFFFFE, 3, 0);
    rd_frame(ctl(RK_QUAD_OUT, 0, 0, 0, 6), rnd(), 2, 0);
    rd_frame(ctl(RK_QUAD_IO, 1, 0, 0, 6), rnd(), 2, 0);
    check("cont_mode", {7'h00, cont_mode}, 8'h01);
    rd_frame(ctl(RK_QUAD_IO, 0, 1, 0, 6), rnd(), 2, 0);
    check("cont_mode", {7'h00, cont_mode}, 8'h00);
    cfg(0, 1, 0, 4'h8);
    rd_frame(ctl(RK_QUAD_IO, 0, 0, 0, 8), rnd(), 1, 0);
    cfg(0, 0, 1, 4'h6);
    rd_frame(ctl(RK_QUAD_IO, 1, 0, 1, 6), rnd(), 2, 0);
    check("cont_mode", {7'h00, cont_mode}, 8'h01);
    rd_frame(ctl(RK_QUAD_IO, 0, 1, 1, 6), rnd(), 1, 0);
    check("cont_mode", {7'h00, cont_mode}, 8'h00);
    cfg(0, 0, 0, 4'h6);
    rd_frame(ctl(RK_QUAD_OUT, 0, 0, 0, 6), rnd(), 1, 1);
    rd_frame(ctl(RK_QUAD_IO, 0, 0, 0, 6), rnd(), 1, 1);
    cfg(1, 1, 0, 4'h6);
    rd_frame(ctl(RK_DUAL, 0, 0, 0, 6), rnd(), 2, 1);
    rd_frame(ctl(RK_QUAD_IO, 0, 0, 0, 6), rnd(), 1, 1);
    cfg(0, 1, 0, 4'h6);
    rd_frame(ctl(RK_DUAL, 0, 0, 0, 6), 24'hFFFFFF, 2, 0);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule : tb_multi_io_fast_read_engine
